// File: design/core_irq_ctrl.sv
// Interrupt control and prescaler option registers behind AHB-Lite.
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
// What this block does
// RULE_01: The option register is read and written at both 81h and 181h.
// RULE_02: One prescaler serves either timer zero or the watchdog, never both.
// RULE_03: With the prescaler on the watchdog, timer zero counts at 1:1.
// RULE_04: Option bits pick the pin edge, timer source, timer edge, pull-ups.
// RULE_05: Interrupt control is one register seen at 0Bh, 8Bh, 10Bh, 18Bh.
// RULE_06: It holds an enable and a flag for overflow, port change and pin.
// RULE_07: A flag sets on its event whatever the enables say.
// RULE_08: Software should clear a flag before setting its enable.
// RULE_09: Bit 6 lets peripheral interrupts through or blocks them all.
// RULE_10: Rate n divides timer zero by 2^(n+1) or the watchdog by 2^n.
// RULE_11: Flags stay set until written zero; port change needs mismatch gone.
module core_irq_ctrl
	import core_irq_pkg::*;
(
	input  wire logic        hclk,            // Core clock, 50 MHz.
	input  wire logic        hresetn,         // Asynchronous reset, low.
	input  wire logic        hsel,            // Slave select.
	input  wire logic [31:0] haddr,           // Byte address.
	input  wire logic [1:0]  htrans,          // Transfer type.
	input  wire logic        hwrite,          // Write when high.
	input  wire logic [2:0]  hsize,           // Transfer size, word only.
	input  wire logic [31:0] hwdata,          // Write data.
	input  wire logic        hready,          // Bus ready.
	output logic             hreadyout,       // Slave ready.
	output logic             hresp,           // Always OKAY.
	output logic [31:0]      hrdata,          // Read data.
	input  wire logic        ext_irq_pin,     // External interrupt pin.
	input  wire logic        timer_zero_pin,  // External timer clock pin.
	input  wire logic [3:0]  port_b_a_pins,   // Watched port pins.
	input  wire logic        port_b_a_read,   // Core read of the port.
	input  wire logic        instr_cycle,     // Internal timer source pulse.
	input  wire logic        watchdog_base,   // Watchdog oscillator pulse.
	input  wire logic        timer_zero_ovf,  // Timer zero overflow pulse.
	input  wire logic        peripheral_irq,  // Unmasked peripheral pending.
	output logic             timer_zero_tick, // Timer zero increment.
	output logic             watchdog_tick,   // Watchdog increment.
	output logic             pullup_disable,  // Port pull-ups off.
	output logic             core_irq_req,    // Interrupt to the core.
	output logic             irq              // Masked event interrupt.
);

	option_t             option_q;
	intctl_t             ictl_q;
	logic [EVT_W-1:0]    status_q;
	logic [EVT_W-1:0]    mask_q;
	reg_sel_t            sel_q;
	logic                wr_pend_q;
	logic                rd_pend_q;
	logic [SYNC_W-1:0]   sync1_q;
	logic [SYNC_W-1:0]   sync2_q;
	logic [SYNC_W-1:0]   sync3_q;
	logic [SYNC_W-1:0]   filt_q;
	logic [SYNC_W-1:0]   prev_q;
	logic [PORT_W-1:0]   port_latch_q;
	logic                take;
	logic                ext_edge;
	logic                pin_edge;
	logic                t0_event;
	logic                mismatch;
	logic                div_step;
	logic                div_pulse;
	logic                div_clear;
	logic [3:0]          div_shift;
	logic [EVT_W-1:0]    events;
	logic                wr_opt;

	// Decode a byte address to the register it selects.
	function automatic reg_sel_t decode(input logic [31:0] a);
		if (a == byte_addr(IDX_ICTL_B0) || a == byte_addr(IDX_ICTL_B1) ||
		    a == byte_addr(IDX_ICTL_B2) || a == byte_addr(IDX_ICTL_B3)) begin
			decode = SEL_ICTL; // [RULE_05]
		end else if (a == byte_addr(IDX_OPT_B1) ||
		             a == byte_addr(IDX_OPT_B3)) begin
			decode = SEL_OPT; // [RULE_01]
		end else if (a == byte_addr(IDX_STATUS)) begin
			decode = SEL_STAT;
		end else if (a == byte_addr(IDX_MASK)) begin
			decode = SEL_MASK;
		end else begin
			decode = SEL_NONE;
		end
	endfunction

	// ***************************************************************
	// AHB-Lite slave.
	// ***************************************************************

	// A transfer is taken on an active address phase while ready.
	assign take   = hsel && htrans[1] && hready;
	assign wr_opt = wr_pend_q && sel_q == SEL_OPT;

	// Address phase capture; reads insert one wait state.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_q     <= SEL_NONE;
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			hreadyout <= 1'b1;
		end else begin
			wr_pend_q <= take && hwrite;
			rd_pend_q <= take && !hwrite;
			hreadyout <= !(take && !hwrite);
			if (take) begin
				sel_q <= decode(haddr);
			end
		end
	end

	// Read data is loaded during the wait state; unmapped reads zero.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0;
			hresp  <= 1'b0;
		end else begin
			hresp <= 1'b0;
			if (rd_pend_q) begin
				unique case (sel_q)
					SEL_ICTL: hrdata <= {24'h0, ictl_q};
					SEL_OPT:  hrdata <= {24'h0, option_q};
					SEL_STAT: hrdata <= {29'h0, status_q};
					SEL_MASK: hrdata <= {29'h0, mask_q};
					SEL_NONE: hrdata <= 32'h0;
				endcase
			end
		end
	end

	// ***************************************************************
	// Pin synchronisers.
	// ***************************************************************

	// Three flops; a change counts once the second and third agree.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
			filt_q  <= '0;
			prev_q  <= '0;
		end else begin
			sync1_q <= {port_b_a_pins, timer_zero_pin, ext_irq_pin};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			prev_q  <= filt_q;
			for (int i = 0; i < SYNC_W; i++) begin
				if (sync2_q[i] == sync3_q[i]) begin
					filt_q[i] <= sync3_q[i];
				end
			end
		end
	end

	// Pin edges chosen by the option edge selects.
	assign ext_edge = option_q.ext_irq_edge_select ?
		(filt_q[0] && !prev_q[0]) : (!filt_q[0] && prev_q[0]); // [RULE_04]
	assign pin_edge = option_q.timer_zero_edge_select ?
		(!filt_q[1] && prev_q[1]) : (filt_q[1] && !prev_q[1]); // [RULE_04]
	assign t0_event = option_q.timer_zero_source_select ?
		pin_edge : instr_cycle; // [RULE_04]

	// Port change latch is refreshed by every read of the port.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_latch_q <= '0;
		end else if (port_b_a_read) begin
			port_latch_q <= filt_q[SYNC_W-1:2];
		end
	end

	assign mismatch = !port_b_a_read && (filt_q[SYNC_W-1:2] != port_latch_q);

	// ***************************************************************
	// Shared prescaler.
	// ***************************************************************

	// Divider input and ratio follow the assignment bit.
	assign div_step  = option_q.prescaler_assign ?
		watchdog_base : t0_event; // [RULE_02]
	assign div_shift = option_q.prescaler_assign ?
		{1'b0, option_q.prescaler_rate} :
		{1'b0, option_q.prescaler_rate} + 4'h1; // [RULE_10]
	assign div_clear = wr_opt &&
		(hwdata[3] != option_q.prescaler_assign); // [RULE_02]

	prescaler_divider #(
		.WIDTH (8)
	) u_div (
		.hclk    (hclk),
		.hresetn (hresetn),
		.clear   (div_clear),
		.step    (div_step),
		.shift_k (div_shift),
		.pulse   (div_pulse)
	);

	// The side without the prescaler runs at its own rate.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timer_zero_tick <= 1'b0;
			watchdog_tick   <= 1'b0;
		end else if (option_q.prescaler_assign) begin
			timer_zero_tick <= t0_event; // [RULE_03]
			watchdog_tick   <= div_pulse; // [RULE_02]
		end else begin
			timer_zero_tick <= div_pulse; // [RULE_02]
			watchdog_tick   <= watchdog_base;
		end
	end

	// ***************************************************************
	// Option and interrupt control registers.
	// ***************************************************************

	// Option register write.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			option_q       <= option_t'(OPTION_RESET);
			pullup_disable <= OPTION_RESET[7];
		end else begin
			if (wr_opt) begin
				option_q <= option_t'(hwdata[7:0]); // [RULE_01]
			end
			pullup_disable <= option_q.pullup_disable; // [RULE_04]
		end
	end

	// Flags set on their events and win over a clearing write.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ictl_q <= intctl_t'(ICTL_RESET);
		end else begin
			if (wr_pend_q && sel_q == SEL_ICTL) begin
				ictl_q <= intctl_t'(hwdata[7:0]); // [RULE_05] [RULE_06]
			end
			if (timer_zero_ovf) begin
				ictl_q.timer_zero_overflow_flag <= 1'b1; // [RULE_07]
			end
			if (ext_edge) begin
				ictl_q.ext_pin_irq_flag <= 1'b1; // [RULE_07]
			end
			if (mismatch) begin
				ictl_q.port_b_a_change_flag <= 1'b1; // [RULE_11]
			end
		end
	end

	// Request to the core under the global enable and each source's own enable.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			core_irq_req <= 1'b0;
		end else begin
			core_irq_req <= ictl_q.global_irq_enable && (
				(ictl_q.timer_zero_overflow_enable &&
				 ictl_q.timer_zero_overflow_flag) ||
				(ictl_q.ext_pin_irq_enable && ictl_q.ext_pin_irq_flag) ||
				(ictl_q.port_b_a_change_enable && ictl_q.port_b_a_change_flag) ||
				(ictl_q.peripheral_irq_enable && peripheral_irq)); // [RULE_09]
		end
	end

	// ***************************************************************
	// Sticky event status, mask and interrupt line.
	// ***************************************************************

	assign events = {timer_zero_ovf, ext_edge, mismatch};

	// Write one to clear; a new event wins over the clear.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_q <= EVT_RESET;
			mask_q   <= EVT_RESET;
			irq      <= 1'b0;
		end else begin
			if (wr_pend_q && sel_q == SEL_STAT) begin
				status_q <= (status_q & ~hwdata[EVT_W-1:0]) | events;
			end else begin
				status_q <= status_q | events;
			end
			if (wr_pend_q && sel_q == SEL_MASK) begin
				mask_q <= hwdata[EVT_W-1:0];
			end
			irq <= |(status_q & mask_q);
		end
	end

	// ***************************************************************
	// Assertions.
	// ***************************************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	opt_alias_a: assert property ( // [RULE_01]
		(take && haddr == byte_addr(IDX_OPT_B3)) |=> sel_q == SEL_OPT)
		else $error("option alias not decoded");

	ictl_alias_a: assert property ( // [RULE_05]
		(take && haddr == byte_addr(IDX_ICTL_B2)) |=> sel_q == SEL_ICTL)
		else $error("interrupt control alias not decoded");

	wdt_direct_a: assert property ( // [RULE_02]
		(watchdog_base && !option_q.prescaler_assign) |=> watchdog_tick)
		else $error("watchdog tick lost without prescaler");

	t0_direct_a: assert property ( // [RULE_03]
		(t0_event && option_q.prescaler_assign) |=> timer_zero_tick)
		else $error("timer zero not at full rate");

	ovf_flag_a: assert property ( // [RULE_07]
		timer_zero_ovf |=> ictl_q.timer_zero_overflow_flag)
		else $error("overflow flag not set");

	pin_flag_a: assert property ( // [RULE_04]
		ext_edge |=> ictl_q.ext_pin_irq_flag)
		else $error("pin flag not set on chosen edge");

	periph_gate_a: assert property ( // [RULE_09]
		(ictl_q.global_irq_enable && ictl_q.peripheral_irq_enable &&
		 peripheral_irq) |=> core_irq_req)
		else $error("peripheral request blocked");

	port_flag_a: assert property ( // [RULE_11]
		mismatch |=> ictl_q.port_b_a_change_flag)
		else $error("port change flag clear during mismatch");

	read_wait_a: assert property (
		(take && !hwrite) |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");

endmodule

// File: shared/core_irq_pkg.sv
// Package with register map, field layouts and reset values of the block.
package core_irq_pkg;

	// ***************************************************************
	// Register indexes; byte address is four times the index.
	// ***************************************************************
	localparam logic [9:0] IDX_ICTL_B0 = 10'h00b; // Interrupt control.
	localparam logic [9:0] IDX_ICTL_B1 = 10'h08b; // Alias in bank 1.
	localparam logic [9:0] IDX_ICTL_B2 = 10'h10b; // Alias in bank 2.
	localparam logic [9:0] IDX_ICTL_B3 = 10'h18b; // Alias in bank 3.
	localparam logic [9:0] IDX_OPT_B1  = 10'h081; // Option configuration.
	localparam logic [9:0] IDX_OPT_B3  = 10'h181; // Alias in bank 3.
	localparam logic [9:0] IDX_STATUS  = 10'h1f0; // Sticky event status.
	localparam logic [9:0] IDX_MASK    = 10'h1f1; // Event mask.

	// ***************************************************************
	// Reset values and widths.
	// ***************************************************************
	localparam logic [7:0] OPTION_RESET = 8'hff;
	localparam logic [7:0] ICTL_RESET   = 8'h00;
	localparam logic [2:0] EVT_RESET    = 3'h0;
	localparam int         EVT_W        = 3;  // Overflow, pin, port change.
	localparam int         PORT_W       = 4;  // Watched port pins.
	localparam int         SYNC_W       = 6;  // Synchronised pins.

	// Option configuration fields.
	typedef struct packed {
		logic       pullup_disable;
		logic       ext_irq_edge_select;
		logic       timer_zero_source_select;
		logic       timer_zero_edge_select;
		logic       prescaler_assign;
		logic [2:0] prescaler_rate;
	} option_t;

	// Interrupt control fields.
	typedef struct packed {
		logic global_irq_enable;
		logic peripheral_irq_enable;
		logic timer_zero_overflow_enable;
		logic ext_pin_irq_enable;
		logic port_b_a_change_enable;
		logic timer_zero_overflow_flag;
		logic ext_pin_irq_flag;
		logic port_b_a_change_flag;
	} intctl_t;

	// Register selected by a bus access.
	typedef enum {SEL_NONE, SEL_ICTL, SEL_OPT, SEL_STAT, SEL_MASK} reg_sel_t;

	// Byte address of a register index.
	function automatic logic [31:0] byte_addr(input logic [9:0] idx);
		byte_addr = {20'h0, idx, 2'b00};
	endfunction

endpackage

// File: design/prescaler_divider.sv
// Shared prescaler counter that divides a pulse train by two to a power.
`timescale 1ns/1ps
module prescaler_divider #(
	parameter int WIDTH = 8 // Counter width, enough for the largest ratio.
) (
	input  wire logic             hclk,    // Core clock.
	input  wire logic             hresetn, // Asynchronous reset, low.
	input  wire logic             clear,   // Restart the count.
	input  wire logic             step,    // Input pulse to divide.
	input  wire logic [3:0]       shift_k, // Ratio is two to this power.
	output logic                  pulse    // One pulse per ratio steps.
);

	logic [WIDTH-1:0] count_q;
	logic [WIDTH-1:0] mask;

	// ***************************************************************
	// Elaboration check.
	// ***************************************************************
	if (WIDTH < 8) begin : g_width_check
		$error("prescaler_divider needs WIDTH of at least 8");
	end

	// Mask of the low bits that must all be one before a pulse.
	function automatic logic [WIDTH-1:0] low_mask(input logic [3:0] k);
		low_mask = ~({WIDTH{1'b1}} << k);
	endfunction

	// Output pulse on the step that completes a full ratio.
	assign mask  = low_mask(shift_k);
	assign pulse = step && ((count_q & mask) == mask); // [RULE_10]

	// Counter advances once per input pulse.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_q <= '0;
		end else if (clear) begin
			count_q <= '0;
		end else if (step) begin
			count_q <= count_q + 1'b1;
		end
	end

	// ***************************************************************
	// Assertions.
	// ***************************************************************
	ratio_one_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(step && shift_k == 4'h0) |-> pulse) // [RULE_10]
		else $error("ratio one did not pass every step");

endmodule

// File: bench/core_irq_ctrl_tb_top.sv
// Self-checking testbench of the interrupt control and option registers.
`timescale 1ns/1ps
module core_irq_ctrl_tb_top;
	import core_irq_pkg::*;

	// ***************************************************************
	// Signals and design instance.
	// ***************************************************************
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        ext_irq_pin, timer_zero_pin, port_b_a_read, instr_cycle;
	logic        watchdog_base, timer_zero_ovf, peripheral_irq;
	logic [3:0]  port_b_a_pins;
	logic        timer_zero_tick, watchdog_tick, pullup_disable;
	logic        core_irq_req, irq;
	int          error_cnt, check_count, tz_cnt, wd_cnt, cyc;

	// The single slave's ready is the bus ready.
	assign hready = hreadyout;

	core_irq_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .ext_irq_pin(ext_irq_pin),
		.timer_zero_pin(timer_zero_pin), .port_b_a_pins(port_b_a_pins),
		.port_b_a_read(port_b_a_read), .instr_cycle(instr_cycle),
		.watchdog_base(watchdog_base), .timer_zero_ovf(timer_zero_ovf),
		.peripheral_irq(peripheral_irq), .timer_zero_tick(timer_zero_tick),
		.watchdog_tick(watchdog_tick), .pullup_disable(pullup_disable),
		.core_irq_req(core_irq_req), .irq(irq));

	// Clock of 20 ns period.
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	// Counts tick pulses and cuts a hang short.
	always @(posedge hclk) begin
		tz_cnt <= tz_cnt + int'(timer_zero_tick === 1'b1);
		wd_cnt <= wd_cnt + int'(watchdog_tick === 1'b1);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			conclude();
		end
	end

	// ***************************************************************
	// Shared tasks.
	// ***************************************************************
	// Prints the verdict and ends the run.
	task automatic conclude();
		if (error_cnt == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Compares one value and reports a mismatch.
	task automatic chk(input string what, input logic [31:0] exp,
			input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One single-word transfer; waits for ready in both phases.
	task automatic bus(input logic wr, input logic [9:0] idx,
			input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {20'h0, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask

	// Register write.
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		logic [31:0] rd;
		bus(1'b1, idx, {24'h0, d}, rd);
	endtask

	// Register read compared with an expected byte.
	task automatic rdc(input string what, input logic [9:0] idx,
			input logic [7:0] exp);
		logic [31:0] rd;
		bus(1'b0, idx, 32'h0, rd);
		chk(what, {24'h0, exp}, rd);
	endtask

	// Drives source pulses on n cycles and returns the ticks seen meanwhile.
	// The counters are only read here, so the counting process stays their
	// one driver.
	task automatic pulses(input int n, output int tz, output int wd);
		int tz0;
		int wd0;
		tz0 = tz_cnt;
		wd0 = wd_cnt;
		repeat (n) begin
			@(posedge hclk);
			instr_cycle <= 1'b1;
			watchdog_base <= 1'b1;
		end
		@(posedge hclk);
		instr_cycle <= 1'b0;
		watchdog_base <= 1'b0;
		repeat (4) @(posedge hclk);
		tz = tz_cnt - tz0;
		wd = wd_cnt - wd0;
	endtask

	// ***************************************************************
	// Scenarios.
	// ***************************************************************
	// Reset values, aliases, pull-up output and an unmapped place.
	task automatic t_map();
		rdc("option reset", IDX_OPT_B1, 8'hff);
		rdc("intctl reset", IDX_ICTL_B0, 8'h00);
		chk("pullup reset", 32'h1, {31'h0, pullup_disable});
		wr(IDX_OPT_B3, 8'h4a);
		rdc("option alias", IDX_OPT_B1, 8'h4a);
		repeat (2) @(posedge hclk);
		chk("pullup off", 32'h0, {31'h0, pullup_disable});
		wr(IDX_ICTL_B1, 8'h38);
		rdc("intctl bank2", IDX_ICTL_B2, 8'h38);
		rdc("intctl bank3", IDX_ICTL_B3, 8'h38);
		wr(IDX_ICTL_B3, 8'h00);
		rdc("intctl bank0", IDX_ICTL_B0, 8'h00);
		wr(10'h040, 8'h55);
		rdc("unmapped", 10'h040, 8'h00);
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask

	// Prescaler assignment and division in both directions.
	task automatic t_presc();
		int tz;
		int wd;
		int tz0;
		wr(IDX_OPT_B1, 8'hca);
		pulses(16, tz, wd);
		chk("tz 1:1", 32'd16, tz);
		chk("wd div4", 32'd4, wd);
		wr(IDX_OPT_B1, 8'hc1);
		pulses(16, tz, wd);
		chk("tz div4", 32'd4, tz);
		chk("wd 1:1", 32'd16, wd);
		wr(IDX_OPT_B1, 8'he8);
		pulses(4, tz, wd);
		chk("tz ignores core", 32'd0, tz);
		chk("wd rate0", 32'd4, wd);
		tz0 = tz_cnt;
		repeat (4) begin
			repeat (4) @(posedge hclk);
			timer_zero_pin <= 1'b1;
			repeat (4) @(posedge hclk);
			timer_zero_pin <= 1'b0;
		end
		repeat (8) @(posedge hclk);
		chk("tz pin edges", 32'd4, tz_cnt - tz0);
		wr(IDX_OPT_B1, 8'hca);
	endtask

	// Overflow flag is sticky and independent of enables.
	task automatic t_flag();
		@(posedge hclk);
		timer_zero_ovf <= 1'b1;
		@(posedge hclk);
		timer_zero_ovf <= 1'b0;
		repeat (2) @(posedge hclk);
		rdc("ovf flag", IDX_ICTL_B0, 8'h04);
		rdc("ovf sticky", IDX_ICTL_B1, 8'h04);
		chk("no req", 32'h0, {31'h0, core_irq_req});
		wr(IDX_ICTL_B0, 8'h00);
		rdc("ovf cleared", IDX_ICTL_B0, 8'h00);
		wr(IDX_ICTL_B0, 8'ha0);
		@(posedge hclk);
		timer_zero_ovf <= 1'b1;
		@(posedge hclk);
		timer_zero_ovf <= 1'b0;
		repeat (3) @(posedge hclk);
		chk("ovf req", 32'h1, {31'h0, core_irq_req});
		wr(IDX_ICTL_B0, 8'h00);
		repeat (2) @(posedge hclk);
		chk("req gone", 32'h0, {31'h0, core_irq_req});
	endtask

	// Peripheral enable passes or blocks the peripheral request.
	task automatic t_periph();
		peripheral_irq <= 1'b1;
		wr(IDX_ICTL_B0, 8'h80);
		repeat (2) @(posedge hclk);
		chk("periph blocked", 32'h0, {31'h0, core_irq_req});
		wr(IDX_ICTL_B0, 8'hc0);
		repeat (2) @(posedge hclk);
		chk("periph passed", 32'h1, {31'h0, core_irq_req});
		peripheral_irq <= 1'b0;
		wr(IDX_ICTL_B0, 8'h00);
	endtask

	// Pin edge and port mismatch flags, status, mask and irq.
	task automatic t_pins();
		ext_irq_pin <= 1'b1;
		port_b_a_pins <= 4'h5;
		repeat (8) @(posedge hclk);
		rdc("pin and port", IDX_ICTL_B0, 8'h03);
		rdc("status", IDX_STATUS, 8'h07);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(IDX_MASK, 8'h02);
		repeat (3) @(posedge hclk);
		chk("irq raised", 32'h1, {31'h0, irq});
		wr(IDX_STATUS, 8'h02);
		repeat (3) @(posedge hclk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		wr(IDX_ICTL_B0, 8'h00);
		rdc("port held", IDX_ICTL_B0, 8'h01);
		@(posedge hclk);
		port_b_a_read <= 1'b1;
		@(posedge hclk);
		port_b_a_read <= 1'b0;
		wr(IDX_ICTL_B0, 8'h00);
		rdc("port cleared", IDX_ICTL_B0, 8'h00);
	endtask

	// ***************************************************************
	// Main sequence.
	// ***************************************************************
	// Sets inputs, resets for two cycles and runs the scenarios.
	initial begin
		{hsel, hwrite, ext_irq_pin, timer_zero_pin, port_b_a_read} = '0;
		{instr_cycle, watchdog_base, timer_zero_ovf, peripheral_irq} = '0;
		{haddr, hwdata, htrans, port_b_a_pins} = '0;
		hsize = 3'h2;
		{error_cnt, check_count, tz_cnt, wd_cnt, cyc} = '0;
		hresetn = 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		t_map();
		t_presc();
		t_flag();
		t_periph();
		t_pins();
		conclude();
	end
endmodule
